/* File: hdl/csao_alu.sv */
// Execute-stage DSP and floating-point clipped operations.
// Assumes issue fields come from logic on core_clk_i; no synchronisers needed.
//
// Notes on behaviour
// - Guard bit 0 low leaves destination unchanged
// - Unsigned subtract clips negative results to zero
// - Unsigned subtract: DSP unit, latency 2, slots 1,3
// - Dual shift right, sign-filled per half
// - Large shift amount fills halves with sign
// - Signed clip halves into minus limit minus one..limit
// - Signed clip: DSP unit, latency 2, slots 1,3
// - Unsigned clip halves into zero..limit
// - Unsigned clip: DSP unit, latency 2, slots 1,3
// - Float absolute value clears negative sign, except on negative zero and NaN
// - Float absolute: float unit, latency 3, slots 1,4
// - Quad byte add clamps into zero..0xff
// - Denormal input gives zero, sets flush flag
`timescale 1ns/10ps
`default_nettype none
`include "csao_map.svh"

module csao_alu
	import csao_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Issue port
	input  wire logic        issue_vld_i,
	input  wire logic [7:0]  opcode_i,
	input  wire logic [2:0]  slot_i,
	input  wire logic        guard_present_i,
	input  wire logic [31:0] guard_i,
	input  wire logic [31:0] first_source_i,
	input  wire logic [31:0] second_source_i,
	input  wire logic [6:0]  dest_i,
	// Status word control
	input  wire logic        flush_clear_i,
	// DSP write-back
	output logic             dsp_wr_o,
	output logic [6:0]       dsp_dest_o,
	output logic [31:0]      dsp_data_o,
	// Float write-back
	output logic             fp_wr_o,
	output logic [6:0]       fp_dest_o,
	output logic [31:0]      fp_data_o,
	// Status and errors
	output logic             input_flush_flag_o,
	output logic             illegal_issue_o
);

	csao_state_t state_reg;
	csao_state_t state_next;

	logic        is_dsp;
	logic        is_fp;
	logic        slot_ok;
	logic        guard_ok;
	logic        dsp_go;
	logic        fp_go;
	logic [31:0] dsp_res;
	logic [31:0] fp_res;
	logic        fp_dnz;

	// Signed 16-bit clamp between lo and hi
	function automatic logic [15:0] clip16(input logic signed [16:0] x,
		input logic signed [16:0] lo, input logic signed [16:0] hi);
		logic signed [16:0] t;
		t = (x < lo) ? lo : x;
		t = (t > hi) ? hi : t;
		return t[15:0];
	endfunction

	// Arithmetic shift of one half, sign-filled
	function automatic logic [15:0] asr16(input logic [15:0] x,
		input logic [3:0] n, input logic big);
		logic signed [15:0] s;
		s = x;
		return big ? {16{x[15]}} : 16'(s >>> n);
	endfunction

	// Unsigned byte plus signed byte, clamped
	function automatic logic [7:0] addb(input logic [7:0] a, input logic [7:0] b);
		logic signed [9:0] t;
		t = $signed({2'h0, a}) + $signed({{2{b[7]}}, b});
		return (t < 0) ? 8'h00 : ((t > 10'sh0ff) ? 8'hff : t[7:0]);
	endfunction

	// Unit and slot decode
	always_comb begin
		is_dsp = (opcode_i == `CSAO_OP_USUB) || (opcode_i == `CSAO_OP_DUALASR) ||
			(opcode_i == `CSAO_OP_QUADADD) || (opcode_i == `CSAO_OP_SCLIP) ||
			(opcode_i == `CSAO_OP_UCLIP);
		is_fp = (opcode_i == `CSAO_OP_FABS);
		slot_ok = (slot_i == `CSAO_SLOT_A) ||
			(is_dsp && slot_i == `CSAO_SLOT_DSP_B) ||
			(is_fp && slot_i == `CSAO_SLOT_FP_B);
		guard_ok = !guard_present_i || guard_i[0];
		dsp_go = issue_vld_i && is_dsp && slot_ok && guard_ok;
		fp_go = issue_vld_i && is_fp && slot_ok && guard_ok;
	end

	// DSP result; limit range is the issuer's duty
	always_comb begin
		logic [32:0] diff;
		logic        big;
		logic signed [16:0] lim;
		diff = {1'b0, first_source_i} - {1'b0, second_source_i};
		big = |second_source_i[31:4];
		lim = $signed({1'b0, second_source_i[15:0]});
		dsp_res = 32'h0;
		case (opcode_i)
			`CSAO_OP_USUB:    dsp_res = diff[32] ? 32'h0 : diff[31:0];
			`CSAO_OP_DUALASR: dsp_res = {asr16(first_source_i[31:16], second_source_i[3:0], big),
				asr16(first_source_i[15:0], second_source_i[3:0], big)};
			`CSAO_OP_SCLIP:   dsp_res = {
				clip16($signed({first_source_i[31], first_source_i[31:16]}), -lim - 17'sh1, lim),
				clip16($signed({first_source_i[15], first_source_i[15:0]}), -lim - 17'sh1, lim)
				};
			`CSAO_OP_UCLIP:   dsp_res = {
				clip16($signed({first_source_i[31], first_source_i[31:16]}), 17'sh0, lim),
				clip16($signed({first_source_i[15], first_source_i[15:0]}), 17'sh0, lim)
				};
			`CSAO_OP_QUADADD: dsp_res = {addb(first_source_i[31:24], second_source_i[31:24]),
				addb(first_source_i[23:16], second_source_i[23:16]),
				addb(first_source_i[15:8], second_source_i[15:8]),
				addb(first_source_i[7:0], second_source_i[7:0])};
			default:          dsp_res = 32'h0;
		endcase
	end

	// Float absolute value with denormal flush
	always_comb begin
		logic nan;
		nan = (first_source_i[30:23] == 8'hff) && (first_source_i[22:0] != 23'h0);
		fp_dnz = (first_source_i[30:23] == 8'h00) && (first_source_i[22:0] != 23'h0);
		if (fp_dnz) begin
			fp_res = 32'h0;
		end else if (nan) begin
			fp_res = first_source_i | 32'h0040_0000; // Signalling becomes quiet
		end else if (first_source_i[31] && first_source_i[30:0] != 31'h0) begin
			fp_res = {1'b0, first_source_i[30:0]};
		end else begin
			fp_res = first_source_i;
		end
	end

	// Next state: fixed-depth pipes, independent ops overlap
	always_comb begin
		state_next = state_reg;
		state_next.d1 = '{vld: dsp_go, dest: dest_i, data: dsp_res, fz: 1'b0};
		state_next.d2 = state_reg.d1;
		state_next.f1 = '{vld: fp_go, dest: dest_i, data: fp_res, fz: fp_go && fp_dnz};
		state_next.f2 = state_reg.f1;
		state_next.f3 = state_reg.f2;
		state_next.bad = issue_vld_i && !((is_dsp || is_fp) && slot_ok);
		// Flag set wins over a clear in the same cycle
		if (flush_clear_i) begin
			state_next.fz_sticky = 1'b0;
		end
		if (state_reg.f2.fz) begin
			state_next.fz_sticky = 1'b1;
		end
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign dsp_wr_o           = state_reg.d2.vld;
	assign dsp_dest_o         = state_reg.d2.dest;
	assign dsp_data_o         = state_reg.d2.data;
	assign fp_wr_o            = state_reg.f3.vld;
	assign fp_dest_o          = state_reg.f3.dest;
	assign fp_data_o          = state_reg.f3.data;
	assign input_flush_flag_o = state_reg.fz_sticky;
	assign illegal_issue_o    = state_reg.bad;

	// Checks
	property p_guard_block;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(issue_vld_i && guard_present_i && !guard_i[0]) |-> ##2 !dsp_wr_o ##1 !fp_wr_o;
	endproperty
	a_guard_block: assert property (p_guard_block) else $error("guarded op wrote");

	property p_usub;
		logic [31:0] a, b;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(dsp_go && opcode_i == `CSAO_OP_USUB, a = first_source_i, b = second_source_i)
		|-> ##2 dsp_wr_o && dsp_data_o == ((a < b) ? 32'h0 : a - b);
	endproperty
	a_usub: assert property (p_usub) else $error("usub result wrong");

	property p_dsp_lat;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		dsp_go |-> ##2 dsp_wr_o && dsp_dest_o == $past(dest_i, 2);
	endproperty
	a_dsp_lat: assert property (p_dsp_lat) else $error("dsp latency wrong");

	// No DSP write-back two cycles after a cycle without an accepted DSP issue
	property p_dsp_quiet;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!dsp_go |-> ##2 !dsp_wr_o;
	endproperty
	a_dsp_quiet: assert property (p_dsp_quiet) else $error("dsp wrote without issue");

	property p_slot;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(issue_vld_i && is_dsp && slot_i != `CSAO_SLOT_A && slot_i != `CSAO_SLOT_DSP_B)
		|-> ##1 illegal_issue_o ##1 !dsp_wr_o;
	endproperty
	a_slot: assert property (p_slot) else $error("bad slot accepted");

	property p_asr_big;
		logic [31:0] a;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(dsp_go && opcode_i == `CSAO_OP_DUALASR && |second_source_i[31:4], a = first_source_i)
		|-> ##2 dsp_data_o == {{16{a[31]}}, {16{a[15]}}};
	endproperty
	a_asr_big: assert property (p_asr_big) else $error("asr fill wrong");

	property p_uclip;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(dsp_go && opcode_i == `CSAO_OP_UCLIP && first_source_i[15]) |-> ##2 dsp_data_o[15:0] == 16'h0;
	endproperty
	a_uclip: assert property (p_uclip) else $error("uclip low half not zero");

	property p_sclip;
		logic [15:0] l;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(dsp_go && opcode_i == `CSAO_OP_SCLIP && first_source_i[31:16] == 16'h8000,
			l = second_source_i[15:0]) |-> ##2 dsp_data_o[31:16] == 16'(~l);
	endproperty
	a_sclip: assert property (p_sclip) else $error("sclip lower bound wrong");

	property p_fabs;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		fp_go |-> ##3 fp_wr_o && (!fp_data_o[31] || fp_data_o == 32'h8000_0000 ||
			(fp_data_o[30:23] == 8'hff && fp_data_o[22:0] != 23'h0));
	endproperty
	a_fabs: assert property (p_fabs) else $error("fabs latency or sign wrong");

	property p_flush;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(fp_go && fp_dnz) |-> ##3 fp_data_o == 32'h0 && input_flush_flag_o;
	endproperty
	a_flush: assert property (p_flush) else $error("flush flag missing");

	// A flush event sets the flag with the write, even against a clear
	property p_flush_set;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		state_reg.f2.fz |=> input_flush_flag_o && fp_wr_o;
	endproperty
	a_flush_set: assert property (p_flush_set) else $error("flush flag lost");

	c_usub_clip: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		dsp_go && opcode_i == `CSAO_OP_USUB && first_source_i < second_source_i);
	c_overlap: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		dsp_wr_o && fp_wr_o);
	c_flush_clr: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_reg.f2.fz && flush_clear_i);

endmodule

`default_nettype wire

/* File: common/csao_map.svh */
// Constants for the clipped SIMD execute operations.
// Assumes inclusion by bare name from the bench and design files.
`ifndef CSAO_MAP_SVH
`define CSAO_MAP_SVH
// Operation codes
`define CSAO_OP_USUB     8'h45
`define CSAO_OP_DUALASR  8'h46
`define CSAO_OP_QUADADD  8'h47
`define CSAO_OP_SCLIP    8'h52
`define CSAO_OP_UCLIP    8'h53
`define CSAO_OP_FABS     8'h73
// Latencies in core clock cycles
`define CSAO_LAT_DSP     2
`define CSAO_LAT_FP      3
// Issue slot numbers
`define CSAO_SLOT_A      3'h1
`define CSAO_SLOT_DSP_B  3'h3
`define CSAO_SLOT_FP_B   3'h4
`endif

/* File: common/csao_pkg.sv */
// Types for the clipped SIMD execute operations.
// Assumes csao_map.svh sits on the include path.
`default_nettype none
package csao_pkg;
	// One pipeline stage of a write-back stream
	typedef struct packed {
		logic        vld;
		logic [6:0]  dest;
		logic [31:0] data;
		logic        fz;
	} csao_stage_t;

	// Whole state of the execute block
	typedef struct packed {
		csao_stage_t d1;
		csao_stage_t d2;
		csao_stage_t f1;
		csao_stage_t f2;
		csao_stage_t f3;
		logic        bad;
		logic        fz_sticky;
	} csao_state_t;
endpackage
`default_nettype wire

/* File: bench/csao_regfile_model.sv */
// Register file model that takes the execute block's write-backs.
// Assumes write-back fields are meaningful only while the strobe is high.
`timescale 1ns/10ps
`default_nettype none
module csao_regfile_model (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Write-back ports
	input  wire logic        dsp_wr_i,
	input  wire logic [6:0]  dsp_dest_i,
	input  wire logic [31:0] dsp_data_i,
	input  wire logic        fp_wr_i,
	input  wire logic [6:0]  fp_dest_i,
	input  wire logic [31:0] fp_data_i,
	// Bench read port
	input  wire logic [6:0]  rd_addr_i,
	output logic [31:0]      rd_data_o
);
	logic [31:0] regs [128];
	// Marker value at reset, strobed writes only
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 128; i++) begin
				regs[i] <= 32'h5a5a5a5a;
			end
		end else begin
			if (dsp_wr_i) begin
				regs[dsp_dest_i] <= dsp_data_i;
			end
			if (fp_wr_i) begin
				regs[fp_dest_i] <= fp_data_i;
			end
		end
	end
	assign rd_data_o = regs[rd_addr_i];
endmodule
`default_nettype wire

/* File: bench/clipped_simd_alu_ops_bench.sv */
// Self-checking bench for the clipped execute operations.
// Assumes csao_map.svh on the include path and csao_pkg compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "csao_map.svh"
module clipped_simd_alu_ops_bench import csao_pkg::*;;
	typedef struct packed {logic [7:0] op; logic [2:0] s; logic [31:0] a, b, e;} csao_row_t;
	logic core_clk_i, rst_n_i, issue_vld_i, guard_present_i, flush_clear_i;
	logic [7:0] opcode_i;
	logic [2:0] slot_i;
	logic [31:0] guard_i, first_source_i, second_source_i, dsp_data_o, fp_data_o, rd_data_o;
	logic [6:0] dest_i, dsp_dest_o, fp_dest_o, rd_addr_i;
	logic dsp_wr_o, fp_wr_o, input_flush_flag_o, illegal_issue_o;
	int mismatches = 0;
	int checks = 0;
	// Clip limits kept in range by the issuer
	csao_row_t rows [16] = '{
		'{`CSAO_OP_USUB, 3'h1, 32'h1200, 32'hff, 32'h1101},
		'{`CSAO_OP_USUB, 3'h3, 32'h0, 32'h1, 32'h0},
		'{`CSAO_OP_USUB, 3'h1, 32'h80000001, 32'hffffffff, 32'h0},
		'{`CSAO_OP_QUADADD, 3'h1, 32'h02010001, 32'hfffff501, 32'h01000002},
		'{`CSAO_OP_QUADADD, 3'h3, 32'h9c9c6464, 32'h649c649c, 32'hff38c800},
		'{`CSAO_OP_DUALASR, 3'h1, 32'h80004000, 32'h4, 32'hf8000400},
		'{`CSAO_OP_DUALASR, 3'h3, 32'h7fff8001, 32'hf, 32'h0000ffff},
		'{`CSAO_OP_DUALASR, 3'h1, 32'h7fff8000, 32'h13, 32'h0000ffff},
		'{`CSAO_OP_SCLIP, 3'h1, 32'h00800080, 32'h7f, 32'h007f007f},
		'{`CSAO_OP_SCLIP, 3'h3, 32'h80008000, 32'h3ff, 32'hfc00fc00},
		'{`CSAO_OP_SCLIP, 3'h1, 32'h800003fe, 32'h3ff, 32'hfc0003fe},
		'{`CSAO_OP_UCLIP, 3'h3, 32'h80008000, 32'h3ff, 32'h0},
		'{`CSAO_OP_UCLIP, 3'h1, 32'h800003fe, 32'h3ff, 32'h000003fe},
		'{`CSAO_OP_FABS, 3'h4, 32'hbf800000, 32'h0, 32'h3f800000},
		'{`CSAO_OP_FABS, 3'h1, 32'hff7fffff, 32'h0, 32'h7f7fffff},
		'{`CSAO_OP_FABS, 3'h4, 32'h40400000, 32'h0, 32'h40400000}};
	csao_alu DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .issue_vld_i(issue_vld_i),
		.opcode_i(opcode_i), .slot_i(slot_i), .guard_present_i(guard_present_i),
		.guard_i(guard_i), .first_source_i(first_source_i), .second_source_i(second_source_i),
		.dest_i(dest_i), .flush_clear_i(flush_clear_i), .dsp_wr_o(dsp_wr_o),
		.dsp_dest_o(dsp_dest_o), .dsp_data_o(dsp_data_o), .fp_wr_o(fp_wr_o),
		.fp_dest_o(fp_dest_o), .fp_data_o(fp_data_o), .input_flush_flag_o(input_flush_flag_o),
		.illegal_issue_o(illegal_issue_o));
	csao_regfile_model model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .dsp_wr_i(dsp_wr_o),
		.dsp_dest_i(dsp_dest_o), .dsp_data_i(dsp_data_o), .fp_wr_i(fp_wr_o),
		.fp_dest_i(fp_dest_o), .fp_data_i(fp_data_o), .rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o));
	// 40 MHz core clock
	always #12.5 core_clk_i = ~core_clk_i;
	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flag compare
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// One issue; hold keeps valid up for a back-to-back follower
	task automatic issue(input logic [7:0] o, input logic [2:0] s, input logic gp,
		input logic [31:0] g, input logic [31:0] a, input logic [31:0] b,
		input logic [6:0] d, input logic hold);
		@(posedge core_clk_i);
		issue_vld_i <= 1'b1;
		opcode_i <= o;
		slot_i <= s;
		guard_present_i <= gp;
		guard_i <= g;
		first_source_i <= a;
		second_source_i <= b;
		dest_i <= d;
		if (!hold) begin
			@(posedge core_clk_i);
			issue_vld_i <= 1'b0;
		end
	endtask
	// Write-back exactly at latency, one cycle wide
	task automatic wb_check(input logic fp, input logic [31:0] e, input logic [6:0] d);
		repeat (fp ? 2 : 1) begin
			#1;
			chkb(dsp_wr_o | fp_wr_o | illegal_issue_o, 1'b0);
			@(posedge core_clk_i);
		end
		#1;
		chkb(fp ? fp_wr_o : dsp_wr_o, 1'b1);
		chk(fp ? fp_data_o : dsp_data_o, e);
		chk({25'h0, fp ? fp_dest_o : dsp_dest_o}, {25'h0, d});
		@(posedge core_clk_i);
		#1;
		chkb(dsp_wr_o | fp_wr_o, 1'b0);
	endtask
	// No write-back for n cycles
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			#1;
			chkb(dsp_wr_o | fp_wr_o | illegal_issue_o, 1'b0);
		end
	endtask
	// Register file content
	task automatic reg_is(input logic [6:0] a, input logic [31:0] e);
		rd_addr_i = a;
		#1;
		chk(rd_data_o, e);
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{core_clk_i, rst_n_i, issue_vld_i, guard_present_i, flush_clear_i} = '0;
		{opcode_i, slot_i, guard_i, first_source_i, second_source_i, dest_i, rd_addr_i} = '0;
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		chk(dsp_data_o | fp_data_o, 32'h0);
		chkb(dsp_wr_o | fp_wr_o | input_flush_flag_o | illegal_issue_o, 1'b0);
		foreach (rows[i]) begin
			issue(rows[i].op, rows[i].s, 1'b0, 32'h0, rows[i].a, rows[i].b, 7'(i), 1'b0);
			wb_check(rows[i].op == `CSAO_OP_FABS, rows[i].e, 7'(i));
		end
		// Guard bit 0 low, even with other bits set
		issue(`CSAO_OP_USUB, 3'h1, 1'b1, 32'h0, 32'h5000, 32'h0, 7'h0, 1'b0);
		quiet(4);
		issue(`CSAO_OP_USUB, 3'h3, 1'b1, 32'hfffffffe, 32'h5000, 32'h0, 7'h0, 1'b0);
		quiet(4);
		reg_is(7'h0, 32'h1101);
		issue(`CSAO_OP_USUB, 3'h3, 1'b1, 32'h3, 32'h5000, 32'h0, 7'h0, 1'b0);
		wb_check(1'b0, 32'h5000, 7'h0);
		// Unknown opcode and wrong slots refused
		for (int k = 0; k < 4; k++) begin
			issue(k == 1 ? 8'h00 : k == 0 ? `CSAO_OP_USUB :
				k == 2 ? `CSAO_OP_FABS : `CSAO_OP_UCLIP,
				k == 0 ? 3'h2 : k == 1 ? 3'h1 : k == 2 ? 3'h3 : 3'h4,
				1'b0, 32'h0, 32'h5, 32'h1, 7'h1, 1'b0);
			#1;
			chkb(illegal_issue_o, 1'b1);
			quiet(4);
		end
		// Denormal under false guard leaves the flag alone
		issue(`CSAO_OP_FABS, 3'h1, 1'b1, 32'h0, 32'h00400000, 32'h0, 7'h2, 1'b0);
		quiet(4);
		chkb(input_flush_flag_o, 1'b0);
		issue(`CSAO_OP_FABS, 3'h4, 1'b1, 32'h1, 32'h80400000, 32'h0, 7'h2, 1'b0);
		repeat (2) begin
			#1;
			chkb(input_flush_flag_o, 1'b0);
			@(posedge core_clk_i);
		end
		#1;
		chkb(input_flush_flag_o & fp_wr_o, 1'b1);
		chk(fp_data_o, 32'h0);
		// Flag stays after the write pulse until the clear is taken
		@(posedge core_clk_i);
		flush_clear_i <= 1'b1;
		#1;
		chkb(input_flush_flag_o, 1'b1);
		@(posedge core_clk_i);
		flush_clear_i <= 1'b0;
		#1;
		chkb(input_flush_flag_o, 1'b0);
		// Clear in the cycle of a new flush event: the set wins
		issue(`CSAO_OP_FABS, 3'h1, 1'b0, 32'h0, 32'h00000001, 32'h0, 7'h3, 1'b0);
		@(posedge core_clk_i);
		flush_clear_i <= 1'b1;
		@(posedge core_clk_i);
		flush_clear_i <= 1'b0;
		#1;
		chkb(input_flush_flag_o & fp_wr_o, 1'b1);
		chk(fp_data_o, 32'h0);
		// Mid-run reset empties the pipes and the flag
		issue(`CSAO_OP_USUB, 3'h1, 1'b0, 32'h0, 32'h9, 32'h1, 7'h23, 1'b0);
		rst_n_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		chkb(dsp_wr_o | fp_wr_o | input_flush_flag_o | illegal_issue_o, 1'b0);
		chk(dsp_data_o | fp_data_o, 32'h0);
		@(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		chkb(dsp_wr_o | fp_wr_o | input_flush_flag_o | illegal_issue_o, 1'b0);
		chk(dsp_data_o | fp_data_o, 32'h0);
		// Back-to-back overlapping operations on both units
		issue(`CSAO_OP_USUB, 3'h3, 1'b0, 32'h0, 32'h10, 32'h20, 7'h20, 1'b1);
		issue(`CSAO_OP_FABS, 3'h1, 1'b0, 32'h0, 32'hc0400000, 32'h0, 7'h21, 1'b1);
		issue(`CSAO_OP_UCLIP, 3'h1, 1'b0, 32'h0, 32'h7fff8000, 32'hff, 7'h22, 1'b0);
		repeat (4) @(posedge core_clk_i);
		reg_is(7'h20, 32'h0);
		reg_is(7'h21, 32'h40400000);
		reg_is(7'h22, 32'h00ff0000);
		summarize();
	end
endmodule
`default_nettype wire
